// File: verilog/sdram_x16_pin_interface.sv
// sdram x16 pin-level command, data and strobe interface
// user commands queue in a fifo and leave one per memory clock
// reads are captured from the returned strobes after synchronisation
//
// Contract
// R1: drive 16-bit row/column address output
// R2: drive 3-bit bank select with commands
// R3: forward memory clock as differential pair
// R4: clock enable low disables, high enables
// R5: two active-low rank selects
// R6: commands encoded on active-low strobes
// R7: byte masks qualify low and high bytes
// R8: strobe driven by whoever sends data
// R9: read data captured on returned strobe
// R10: strobe lanes follow byte lanes
// R11: drive on-die termination control output
// R12: write strobe centred in data window
`timescale 1ns/1ps
`include "sdram_pin_consts.svh"
`default_nettype none

// command fifo, width and depth set by parameters
module cmd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  // pointer width; depth must be a power of two or the wrap breaks
  localparam int AW = $clog2(DEPTH);

  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];  // storage array
  logic [AW:0]      wr_ptr;       // extra bit tells full from empty
  logic [AW:0]      rd_ptr;       // head of the queue
  logic [AW:0]      next_wr_ptr;  // write pointer after this cycle
  logic [AW:0]      next_rd_ptr;  // read pointer after this cycle
  logic             push;         // entry taken this cycle
  logic             pop;          // head released this cycle

  // flags from the pointer difference; ready drops only when every slot is used
  // head word is read straight from the array, so it is valid as soon as written
  always_comb begin
    out_valid   = (wr_ptr != rd_ptr);
    in_ready    = (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]) || (wr_ptr[AW] == rd_ptr[AW]);
    push        = in_valid && in_ready;
    pop         = out_valid && out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    out_data    = mem[rd_ptr[AW-1:0]];
  end

  // pointers
  // reset empties the queue; stored words need no clearing
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // array write, no reset needed on data
  // a stale word is never used, since valid follows the pointers
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : cmd_fifo

// pin engine: sends one queued command per memory clock period
module sdram_x16_pin_interface (
  input  wire logic                      mclk,
  input  wire logic                      rst,
  input  wire sdram_pin_pkg::mem_cmd_type cmd_data,
  input  wire logic                      cmd_valid,
  output logic                           cmd_ready,
  input  wire logic                      clk_enable,
  input  wire logic                      term_enable,
  output logic [15:0]                    rd_data,
  output logic                           rd_valid,
  output logic                           mem_clk_true,
  output logic                           mem_clk_comp,
  output logic                           mem_clk_en,
  output logic [1:0]                     mem_rank_sel_n,
  output logic                           mem_row_strobe_n,
  output logic                           mem_col_strobe_n,
  output logic                           mem_write_en_n,
  output logic [15:0]                    mem_addr,
  output logic [2:0]                     mem_bank,
  output logic                           mem_low_byte_mask,
  output logic                           mem_high_byte_mask,
  input  wire logic [15:0]               mem_data_in,
  output logic [15:0]                    mem_data_out,
  output logic                           mem_data_oe_n,
  input  wire logic                      mem_low_strobe_in,
  output logic                           mem_low_strobe_true,
  output logic                           mem_low_strobe_comp,
  output logic                           mem_low_strobe_oe_n,
  input  wire logic                      mem_high_strobe_in,
  output logic                           mem_high_strobe_true,
  output logic                           mem_high_strobe_comp,
  output logic                           mem_high_strobe_oe_n,
  output logic                           mem_term_ctrl
);
  import sdram_pin_pkg::*;

  localparam int LANES = 2;  // byte lanes on the x16 bus

  // queue side
  mem_cmd_type   q_cmd;           // fifo head
  logic          q_valid;         // head holds a command
  logic          q_pop;           // head taken onto the pins
  // command slot on the pins
  mem_cmd_type   cur;             // command on the pins
  mem_cmd_type   next_cur;        // command for the next slot
  // slot kind, which decides who drives data and strobes
  pin_state_type state;
  pin_state_type next_state;
  // forwarded clock and level controls
  logic [3:0]    div_cnt;         // memory clock divider
  logic [3:0]    next_div_cnt;
  logic          tick;            // one cycle at each rising memory clock
  logic          ck;              // divided memory clock level
  logic          next_ck;
  logic          cke;
  logic          next_cke;
  logic          odt;
  logic          next_odt;
  logic          wstrobe;         // write strobe level
  logic          next_wstrobe;
  // read path; strobes and data come from the far side's timing
  logic [LANES-1:0] dqs_s1;       // synchroniser stage one
  logic [LANES-1:0] dqs_s2;       // synchronised strobes
  logic [LANES-1:0] dqs_s3;       // previous value, for edge find
  logic [15:0]   dq_s1;           // data synchroniser stage one
  logic [15:0]   dq_s2;           // synchronised data
  wire  logic [LANES-1:0] lane_edge;  // strobe edge seen per lane
  wire  logic [15:0]      lane_pick;  // fresh byte where its lane moved
  logic [15:0]   next_rd_data;
  logic          next_rd_valid;

  // queue between the user side and the pins; back-pressure via cmd_ready
  cmd_fifo #(
    .WIDTH ($bits(mem_cmd_type)),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst       (rst),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .in_data   (cmd_data),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_cmd)
  );

  // divider makes the forwarded clock and the command tick
  // clock rises as each slot starts; both enables just pass through a flop
  // mclk/4 keeps every pin driven from flops with at most a small decode, at the cost of bandwidth
  always_comb begin
    tick         = (div_cnt == `CLK_DIV - 4'h1);
    next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
    next_ck      = (next_div_cnt < `CLK_HALF);
    next_cke     = clk_enable;
    next_odt     = term_enable;
  end

  // command state: one command per tick, fifo pops only on a tick
  // clock enable low freezes the queue; the slot falls back to a nop
  // no sdram timing is kept here, the user must space dependent commands
  always_comb begin
    next_state = state;
    next_cur   = cur;
    q_pop      = 1'b0;
    case (state)
      st_idle, st_cmd, st_wr, st_rd: begin
        if (tick) begin
          if (q_valid && cke) begin
            q_pop    = 1'b1;
            next_cur = q_cmd;
            case (q_cmd.code)
              `CMD_WR: next_state = st_wr;
              `CMD_RD: next_state = st_rd;
              default: next_state = st_cmd;
            endcase
          end else begin
            // empty queue or stopped clock: idle slot, pins hold address
            next_cur.code = `CMD_NOP;
            next_state    = st_idle;
          end
        end
      end
      default: next_state = st_idle;
    endcase
  end

  // write strobe toggles at half-slot points, mid-bit for data set at the tick
  // data, mask and address change only at a tick, so the rise two
  // cycles in has two cycles of settled data on either side
  always_comb begin
    next_wstrobe = wstrobe;
    if (state != st_wr) begin
      next_wstrobe = 1'b0;
    end else if (div_cnt == `CLK_HALF - 4'h1) begin
      next_wstrobe = 1'b1;  // R12
    end else if (tick) begin
      next_wstrobe = 1'b0;  // R12
    end
  end

  // one capture lane per byte; each lane follows only its own strobe
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // either edge counts, since the far side toggles once per data beat
    assign lane_edge[g]        = dqs_s2[g] ^ dqs_s3[g];  // R10
    assign lane_pick[8*g +: 8] = lane_edge[g] ? dq_s2[8*g +: 8]  // R9 R10
                                              : rd_data[8*g +: 8];
  end

  // read capture: edges outside a read slot are ignored, so a
  // released strobe or a stray glitch cannot overwrite the last word
  // limitation: the two-flop path only keeps up with a slow far side
  always_comb begin
    next_rd_data  = rd_data;
    next_rd_valid = 1'b0;
    if (state == st_rd && (|lane_edge)) begin
      next_rd_data  = lane_pick;  // R9 R10
      next_rd_valid = 1'b1;       // R9
    end
  end

  // registers of the pin engine
  // reset parks the pins at a nop with the clock high and no driver on
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      div_cnt  <= 4'h0;
      ck       <= 1'b1;
      cke      <= 1'b0;
      odt      <= 1'b0;
      state    <= st_idle;
      cur      <= '{code: `CMD_NOP, default: '0};
      wstrobe  <= 1'b0;
      dqs_s1   <= '0;
      dqs_s2   <= '0;
      dqs_s3   <= '0;
      dq_s1    <= 16'h0000;
      dq_s2    <= 16'h0000;
      rd_data  <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      div_cnt  <= next_div_cnt;
      ck       <= next_ck;
      cke      <= next_cke;
      odt      <= next_odt;
      state    <= next_state;
      cur      <= next_cur;
      wstrobe  <= next_wstrobe;
      dqs_s1   <= {mem_high_strobe_in, mem_low_strobe_in};
      dqs_s2   <= dqs_s1;
      dqs_s3   <= dqs_s2;
      dq_s1    <= mem_data_in;
      dq_s2    <= dq_s1;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  // pin drive, all from flip-flops
  // both strobe lanes share one write strobe, since a write slot always
  // carries a full 16-bit word; masks blank whichever byte is unwanted
  always_comb begin
    mem_clk_true     = ck;   // R3
    mem_clk_comp     = ~ck;  // R3
    mem_clk_en       = cke;  // R4
    mem_term_ctrl    = odt;  // R11
    mem_addr         = cur.addr;  // R1
    mem_bank         = cur.bank;  // R2
    mem_rank_sel_n   = (cur.code == `CMD_NOP) ? `RANK_IDLE
                     : (cur.rank ? 2'b01 : 2'b10);  // R5 R6
    mem_row_strobe_n = cur.code[2];  // R6
    mem_col_strobe_n = cur.code[1];  // R6
    mem_write_en_n   = cur.code[0];  // R6
    mem_data_out     = cur.wdata;
    mem_data_oe_n    = (state != st_wr);  // R8
    mem_low_byte_mask  = (state == st_wr) && cur.mask[0];  // R7
    mem_high_byte_mask = (state == st_wr) && cur.mask[1];  // R7
    mem_low_strobe_true  = wstrobe;   // R8 R10
    mem_low_strobe_comp  = ~wstrobe;
    mem_high_strobe_true = wstrobe;   // R8 R10
    mem_high_strobe_comp = ~wstrobe;
    mem_low_strobe_oe_n  = (state != st_wr);  // R8
    mem_high_strobe_oe_n = (state != st_wr);  // R8
  end
endmodule : sdram_x16_pin_interface
`default_nettype wire

// File: verilog/sdram_pin_consts.svh
// constants for the sdram pin interface
`ifndef SDRAM_PIN_CONSTS_SVH
`define SDRAM_PIN_CONSTS_SVH
`define ADDR_W        16
`define BANK_W        3
`define DATA_W        16
`define RANKS         2
`define FIFO_DEPTH    32
`define CLK_DIV       4'h4
`define CLK_HALF      4'h2
`define CMD_NOP       3'h7
`define CMD_ACT       3'h3
`define CMD_RD        3'h5
`define CMD_WR        3'h4
`define CMD_PRE       3'h2
`define CMD_REF       3'h1
`define CMD_MRS       3'h0
`define RANK_IDLE     2'h3
`endif

// File: verilog/sdram_pin_pkg.sv
// types for the sdram pin interface
`default_nettype none
package sdram_pin_pkg;
  typedef struct packed {
    logic [2:0]  code;  // ras cas we, active low
    logic        rank;  // target rank
    logic [2:0]  bank;  // bank select
    logic [15:0] addr;  // row or column address
    logic [15:0] wdata; // write data
    logic [1:0]  mask;  // byte masks, high then low
  } mem_cmd_type;
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_cmd  = 4'b0010,
    st_wr   = 4'b0100,
    st_rd   = 4'b1000
  } pin_state_type;
endpackage : sdram_pin_pkg
`default_nettype wire

// File: test/sdram_pin_sva.sv
// port-level assertion checker for the sdram pin interface
`timescale 1ns/1ps
`default_nettype none
module sdram_pin_sva (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       clk_enable,
  input wire logic       term_enable,
  input wire logic       mem_clk_true,
  input wire logic       mem_clk_comp,
  input wire logic       mem_clk_en,
  input wire logic [1:0] mem_rank_sel_n,
  input wire logic       mem_row_strobe_n,
  input wire logic       mem_col_strobe_n,
  input wire logic       mem_write_en_n,
  input wire logic       mem_low_byte_mask,
  input wire logic       mem_high_byte_mask,
  input wire logic       mem_data_oe_n,
  input wire logic       mem_low_strobe_true,
  input wire logic       mem_low_strobe_comp,
  input wire logic       mem_low_strobe_oe_n,
  input wire logic       mem_high_strobe_oe_n,
  input wire logic       mem_high_strobe_true,
  input wire logic       mem_high_strobe_comp,
  input wire logic       mem_term_ctrl
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // write strobe starts low, then rises mid-slot
  sequence strobe_pulse;
    !mem_low_strobe_true ##[1:3] mem_low_strobe_true;
  endsequence
  // forwarded clock after a rise: high again, two low, then high
  sequence clk_shape;
    mem_clk_true ##1 !mem_clk_true[*2] ##1 mem_clk_true;
  endsequence
  clk_pair_a: assert property (mem_clk_comp == !mem_clk_true)
    else $error("clock pair not inverse");
  clk_period_a: assert property ($rose(mem_clk_true) |-> ##1 clk_shape)
    else $error("memory clock not mclk/4");
  cke_follow_a: assert property (1 |=> mem_clk_en == $past(clk_enable))
    else $error("clock enable lost");
  term_follow_a: assert property (1 |=> mem_term_ctrl == $past(term_enable))
    else $error("termination control lost");
  rank_sel_a: assert property (mem_rank_sel_n != 2'b00) else $error("both ranks");
  write_cmd_a: assert property (!mem_data_oe_n |-> mem_rank_sel_n != 2'b11 &&
    mem_row_strobe_n && !mem_col_strobe_n && !mem_write_en_n) else $error("drive w/o write");
  mask_idle_a: assert property (mem_data_oe_n |-> !mem_low_byte_mask &&
    !mem_high_byte_mask) else $error("mask outside write");
  strobe_dir_a: assert property (!mem_low_strobe_oe_n || !mem_high_strobe_oe_n
    |-> !mem_data_oe_n) else $error("strobe driven outside write");
  strobe_pair_a: assert property (!mem_low_strobe_oe_n |->
    mem_low_strobe_comp == !mem_low_strobe_true) else $error("strobe pair not inverse");
  strobe_high_a: assert property (!mem_high_strobe_oe_n |->
    mem_high_strobe_comp == !mem_high_strobe_true &&
    mem_high_strobe_true == mem_low_strobe_true) else $error("high strobe pair wrong");
  write_strobe_a: assert property ($fell(mem_data_oe_n) |-> strobe_pulse)
    else $error("write strobe not centred");
endmodule : sdram_pin_sva
`default_nettype wire

// File: test/sdram_x16_model.sv
// behavioural sdram answering reads with a word and strobe edges
`timescale 1ns/1ps
`default_nettype none
module sdram_x16_model #(
  parameter logic [15:0] RD_WORD = 16'hc35a
) (
  input  wire logic       mclk,
  input  wire logic [1:0] mem_rank_sel_n,
  input  wire logic       mem_row_strobe_n,
  input  wire logic       mem_col_strobe_n,
  input  wire logic       mem_write_en_n,
  output var  logic [15:0] model_dq,
  output var  logic       model_lo,
  output var  logic       model_hi
);
  // one read per pass; the delays outlast the slot so it fires once
  initial begin
    model_dq = 16'h0000;
    model_lo = 1'b0;
    model_hi = 1'b0;
    forever begin
      @(posedge mclk);
      if (mem_rank_sel_n != 2'b11 && mem_row_strobe_n && !mem_col_strobe_n && mem_write_en_n) begin
        #1 model_dq = RD_WORD;
        model_lo = !model_lo;
        model_hi = !model_hi;
        #100 model_lo = !model_lo; // second edge, one memory clock period later
        model_hi = !model_hi;
        // released: inverse values so stale data never looks valid
        #25 model_dq = ~model_dq;
        model_lo = !model_lo;
        model_hi = !model_hi;
      end
    end
  end
endmodule : sdram_x16_model
`default_nettype wire

// File: test/tb_sdram_x16_pin_interface.sv
// self-checking bench for the sdram pin interface
`timescale 1ns/1ps
`default_nettype none
`include "sdram_pin_consts.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module tb_sdram_x16_pin_interface;
  import sdram_pin_pkg::*;
  mem_cmd_type cmd_data;
  logic mclk, rst, cmd_valid, cmd_ready, clk_enable, term_enable, rd_valid;
  logic mem_clk_true, mem_clk_comp, mem_clk_en, mem_term_ctrl, mem_data_oe_n;
  logic mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n;
  logic mem_low_byte_mask, mem_high_byte_mask, model_lo, model_hi;
  logic mem_low_strobe_in, mem_low_strobe_true, mem_low_strobe_comp, mem_low_strobe_oe_n;
  logic mem_high_strobe_in, mem_high_strobe_true, mem_high_strobe_comp, mem_high_strobe_oe_n;
  logic [15:0] rd_data, mem_addr, mem_data_in, mem_data_out, model_dq;
  logic [2:0]  mem_bank;
  logic [1:0]  mem_rank_sel_n;
  int          error_cnt, cmp_count;
  // pin levels resolved from the interface's output enables
  assign mem_data_in = mem_data_oe_n ? model_dq : mem_data_out;
  assign mem_low_strobe_in = mem_low_strobe_oe_n ? model_lo : mem_low_strobe_true;
  assign mem_high_strobe_in = mem_high_strobe_oe_n ? model_hi : mem_high_strobe_true;
  sdram_x16_pin_interface uut (.*);
  sdram_x16_model model (.*);
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : tick
  // offer one command and hold it until taken
  task automatic push(input logic [2:0] code, input logic rank);
    cmd_data = '{code, rank, 3'h5, 16'ha1b2, 16'h3c4d, 2'b10};
    cmd_valid = 1'b1;
    for (int n = 0; cmd_ready !== 1'b1; n++) begin
      if (n == 50) begin error_cnt++; end_of_test(); end
      tick(1);
    end
    tick(1);
    cmd_valid = 1'b0;
  endtask : push
  // wait for a command slot to start or end
  task automatic wait_slot(input logic busy);
    for (int n = 0; (mem_rank_sel_n !== 2'b11) !== busy; n++) begin
      if (n == 200) begin error_cnt++; end_of_test(); end
      tick(1);
    end
  endtask : wait_slot
  task automatic t_write;
    push(`CMD_WR, 1'b0);
    wait_slot(1'b1);
    `CHK(mem_addr, 16'ha1b2)
    `CHK(mem_bank, 3'h5)
    `CHK(mem_rank_sel_n, 2'b10)
    `CHK({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}, `CMD_WR)
    `CHK({mem_data_oe_n, mem_data_out}, {1'b0, 16'h3c4d})
    `CHK({mem_high_byte_mask, mem_low_byte_mask}, 2'b10)
    wait_slot(1'b0);
  endtask : t_write
  task automatic t_cmds;
    logic [2:0] codes[4] = '{`CMD_ACT, `CMD_PRE, `CMD_REF, `CMD_MRS};
    foreach (codes[i]) begin
      push(codes[i], 1'b1);
      wait_slot(1'b1);
      `CHK({mem_row_strobe_n, mem_col_strobe_n, mem_write_en_n}, codes[i])
      `CHK({mem_rank_sel_n, mem_high_byte_mask, mem_low_byte_mask}, 4'h4)
      wait_slot(1'b0);
    end
  endtask : t_cmds
  // termination control follows its input one cycle later, both ways
  task automatic t_term;
    term_enable = 1'b0;
    tick(1);
    `CHK(mem_term_ctrl, 1'b0)
    term_enable = 1'b1;
    tick(1);
    `CHK(mem_term_ctrl, 1'b1)
  endtask : t_term
  // read word arrives on strobe; edges after the slot are ignored
  task automatic t_read;
    push(`CMD_RD, 1'b0);
    for (int n = 0; rd_valid !== 1'b1; n++) begin
      if (n == 20) begin error_cnt++; end_of_test(); end
      tick(1);
    end
    `CHK(rd_data, 16'hc35a)
    tick(12);
    `CHK(rd_data, 16'hc35a)
  endtask : t_read
  // clock enable low stalls the queue; fill the fifo, then drain
  task automatic t_fill;
    int n;
    clk_enable = 1'b0;
    tick(2);
    `CHK(mem_clk_en, 1'b0)
    cmd_data = '{`CMD_PRE, 1'b0, 3'h2, 16'h0400, 16'h0000, 2'b00};
    cmd_valid = 1'b1;
    for (n = 0; cmd_ready === 1'b1 && n < 40; n++) tick(1);
    cmd_valid = 1'b0;
    `CHK(n, `FIFO_DEPTH)
    `CHK(mem_rank_sel_n, `RANK_IDLE)
    clk_enable = 1'b1;
    wait_slot(1'b1);
    `CHK(mem_bank, 3'h2)
    tick(140);
    `CHK({mem_rank_sel_n, cmd_ready}, 3'h7)
  endtask : t_fill
  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_data = '0;
    clk_enable = 1'b1;
    term_enable = 1'b1;
    repeat (12) @(posedge mclk);
    #2 rst = 1'b0;
    tick(1);
    `CHK(mem_term_ctrl, 1'b1)
    t_term();
    t_write();
    t_cmds();
    t_read();
    t_fill();
    end_of_test();
  end
endmodule : tb_sdram_x16_pin_interface
bind sdram_x16_pin_interface sdram_pin_sva chk (.*);
`default_nettype wire
